// ### msc_pkg.sv
// Purpose: constants for the motor startup configuration register bank
// Assumes: one 32-bit register on a classic Wishbone slave
// Notes: decode tables give values in fixed-point units named per table
package msc_pkg;
    localparam logic [7:0] MSC_CFG1_OFFSET = 8'h84;
    localparam logic [31:0] MSC_CFG1_RESET = 32'h00000000;
    // writable bits, 31 and 8 are reserved
    localparam logic [31:0] MSC_CFG1_WMASK = 32'h7ffffeff;
    localparam int MSC_METHOD_LSB = 29;
    localparam int MSC_RAMP_LSB = 25;
    localparam int MSC_ALIGN_T_LSB = 21;
    localparam int MSC_LOCK_CAP_LSB = 17;
    localparam int MSC_PROBE_RATE_LSB = 14;
    localparam int MSC_PROBE_THR_LSB = 9;
    localparam int MSC_PROBE_ANG_LSB = 6;
    localparam int MSC_PROBE_REP_LSB = 4;
    localparam int MSC_OL_SRC_BIT = 3;
    localparam int MSC_RAMPDN_BIT = 2;
    localparam int MSC_BRAKE_BIT = 1;
    localparam int MSC_BACKWARD_BIT = 0;
    typedef enum logic [1:0] {
        MSC_START_ALIGN,
        MSC_START_DOUBLE_ALIGN,
        MSC_START_POSITION_DETECT,
        MSC_START_SLOW_FIRST_CYCLE
    } msc_start_t;
    typedef enum {MSC_BUS_IDLE, MSC_BUS_ACK} msc_bus_t;
endpackage

// ### msc_decode.sv
// Purpose: decode percentage-of-full-scale current cap codes
// Assumes: code is a four-bit field
// Notes: result is in tenths of a percent
`timescale 1ns/100ps
module msc_decode
    import msc_pkg::*;
(
    // code in
    input wire logic [3:0] code_i,
    // tenths of percent out
    output logic [9:0] permille_o
);
    always_comb begin
        case (code_i)
            4'h0: permille_o = 10'd50;
            4'h1: permille_o = 10'd100;
            4'h2: permille_o = 10'd150;
            4'h3: permille_o = 10'd200;
            4'h4: permille_o = 10'd250;
            4'h5: permille_o = 10'd300;
            4'h6: permille_o = 10'd400;
            4'h7: permille_o = 10'd500;
            4'h8: permille_o = 10'd600;
            4'h9: permille_o = 10'd650;
            4'ha: permille_o = 10'd700;
            4'hb: permille_o = 10'd750;
            4'hc: permille_o = 10'd800;
            4'hd: permille_o = 10'd850;
            4'he: permille_o = 10'd900;
            default: permille_o = 10'd950;
        endcase
    end
endmodule

// ### msc_top.sv
// Purpose: motor startup configuration register with decoded controls
// Assumes: classic Wishbone slave, single clock, synchronous reset
// Notes: decoded values go to the startup engine outside this block
// Function
// - method code 0..3 selects align, double align, position detection, slow first cycle.
// - ramp code steps rate from 1 A/s to 50000 A/s, code f meaning no limit.
// - align duration codes map from 10 ms to 10 s.
// - align and slow cycle current cap runs from 5 % to 95 % of full scale current.
// - position probe pulse rate runs from 50 Hz to 10000 Hz.
// - probe threshold runs from 2.5 % to 72 %, codes 10h up are not applicable.
// - probe advance angle adds 0, 30, 60 or 90 degrees.
// - repeat code runs detection 1 to 4 times, averaging only when it runs more than once.
// - limit source bit 0 takes dedicated open loop cap, 1 the general cap.
// - rampdown bit enables torque reference ramp-down at closed loop handoff.
// - active braking only while the brake enable bit is one.
// - backward bit picks reverse or forward open loop current select and A1, A2; the dedicated cap decode uses the forward code only.
// - dedicated open loop cap runs from 5 % to 95 % of full scale current.
`timescale 1ns/100ps
module msc_top
    import msc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // current caps, accel selects and reverse request supplied by neighbouring logic
    input wire logic [9:0] general_current_cap_i,
    input wire logic [3:0] open_loop_current_cap_i,
    input wire logic [3:0] reverse_open_loop_cap_i,
    input wire logic [3:0] forward_accel_a1_i,
    input wire logic [3:0] forward_accel_a2_i,
    input wire logic [3:0] reverse_accel_a1_i,
    input wire logic [3:0] reverse_accel_a2_i,
    input wire logic reverse_active_i,
    // decoded startup controls
    output logic [1:0] startup_method_select_o,
    output logic method_align_o,
    output logic method_double_align_o,
    output logic method_position_detect_o,
    output logic method_slow_cycle_o,
    output logic [15:0] ramp_rate_amps_o,
    output logic ramp_unlimited_o,
    output logic [13:0] align_time_ms_o,
    output logic [9:0] rotor_lock_current_cap_o,
    output logic [13:0] position_probe_pulse_rate_o,
    output logic [9:0] position_probe_current_threshold_o,
    output logic probe_threshold_valid_o,
    output logic [6:0] position_probe_advance_angle_o,
    output logic [2:0] position_probe_repeat_count_o,
    output logic probe_average_o,
    output logic [9:0] open_loop_cap_o,
    output logic torque_ref_rampdown_enable_o,
    output logic active_brake_enable_o,
    output logic [3:0] open_loop_current_sel_o,
    output logic [3:0] accel_a1_sel_o,
    output logic [3:0] accel_a2_sel_o
);
    // ****************************************
    // register and bus
    // ****************************************
    logic [31:0] cfg_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic hit;
    logic [31:0] byte_mask;

    assign hit = (adr_i == MSC_CFG1_OFFSET);
    assign byte_mask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    // one wait state, ack drops the cycle after it is given
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
        end
    end

    // write lands on the taking edge, one edge before ack is sampled
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= MSC_CFG1_RESET;
        end else if (cyc_i && stb_i && !ack_q && we_i && hit) begin
            // reserved bits never stored
            cfg_q <= (cfg_q & ~(byte_mask & MSC_CFG1_WMASK))
                | (dat_i & byte_mask & MSC_CFG1_WMASK);
        end
    end

    // unmapped reads return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h00000000;
        end else if (cyc_i && stb_i && !ack_q) begin
            dat_q <= hit ? (cfg_q & MSC_CFG1_WMASK) : 32'h00000000;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ****************************************
    // field decode
    // ****************************************
    logic [1:0] method;
    logic [3:0] ramp_code;
    logic [3:0] align_code;
    logic [3:0] lock_code;
    logic [2:0] rate_code;
    logic [4:0] thr_code;
    logic [1:0] ang_code;
    logic [1:0] rep_code;
    logic [9:0] lock_cap;
    logic [9:0] ol_cap;
    logic [3:0] ol_code;
    logic [15:0] rate_amps_d;
    logic [15:0] rate_amps_q;
    logic unl_d;
    logic unl_q;
    logic [13:0] align_ms_d;
    logic [13:0] align_ms_q;
    logic [13:0] pulse_hz_d;
    logic [13:0] pulse_hz_q;
    logic [9:0] thr_pct_d;
    logic [9:0] thr_pct_q;
    logic thr_ok_d;
    logic thr_ok_q;
    logic [9:0] lock_cap_q;
    logic [9:0] ol_pick_q;
    logic [6:0] ang_d;
    logic [6:0] ang_q;
    logic [2:0] rep_d;
    logic [2:0] rep_q;
    logic avg_d;
    logic avg_q;

    assign method = cfg_q[MSC_METHOD_LSB +: 2];
    assign ramp_code = cfg_q[MSC_RAMP_LSB +: 4];
    assign align_code = cfg_q[MSC_ALIGN_T_LSB +: 4];
    assign lock_code = cfg_q[MSC_LOCK_CAP_LSB +: 4];
    assign rate_code = cfg_q[MSC_PROBE_RATE_LSB +: 3];
    assign thr_code = cfg_q[MSC_PROBE_THR_LSB +: 5];
    assign ang_code = cfg_q[MSC_PROBE_ANG_LSB +: 2];
    assign rep_code = cfg_q[MSC_PROBE_REP_LSB +: 2];

    always_comb begin
        method_align_o = 1'b0;
        method_double_align_o = 1'b0;
        method_position_detect_o = 1'b0;
        method_slow_cycle_o = 1'b0;
        case (msc_start_t'(method))
            MSC_START_ALIGN: method_align_o = 1'b1;
            MSC_START_DOUBLE_ALIGN: method_double_align_o = 1'b1;
            MSC_START_POSITION_DETECT: method_position_detect_o = 1'b1;
            default: method_slow_cycle_o = 1'b1;
        endcase
    end
    assign startup_method_select_o = method;

    always_comb begin
        unl_d = 1'b0;
        case (ramp_code)
            4'h0: rate_amps_d = 16'd1;
            4'h1: rate_amps_d = 16'd5;
            4'h2: rate_amps_d = 16'd10;
            4'h3: rate_amps_d = 16'd25;
            4'h4: rate_amps_d = 16'd50;
            4'h5: rate_amps_d = 16'd100;
            4'h6: rate_amps_d = 16'd150;
            4'h7: rate_amps_d = 16'd250;
            4'h8: rate_amps_d = 16'd500;
            4'h9: rate_amps_d = 16'd1000;
            4'ha: rate_amps_d = 16'd2000;
            4'hb: rate_amps_d = 16'd5000;
            4'hc: rate_amps_d = 16'd10000;
            4'hd: rate_amps_d = 16'd20000;
            4'he: rate_amps_d = 16'd50000;
            default: begin
                // no limit: rate reads as all ones
                rate_amps_d = 16'hffff;
                unl_d = 1'b1;
            end
        endcase
    end

    always_comb begin
        case (align_code)
            4'h0: align_ms_d = 14'd10;
            4'h1: align_ms_d = 14'd50;
            4'h2: align_ms_d = 14'd100;
            4'h3: align_ms_d = 14'd200;
            4'h4: align_ms_d = 14'd300;
            4'h5: align_ms_d = 14'd400;
            4'h6: align_ms_d = 14'd500;
            4'h7: align_ms_d = 14'd750;
            4'h8: align_ms_d = 14'd1000;
            4'h9: align_ms_d = 14'd1500;
            4'ha: align_ms_d = 14'd2000;
            4'hb: align_ms_d = 14'd3000;
            4'hc: align_ms_d = 14'd4000;
            4'hd: align_ms_d = 14'd5000;
            4'he: align_ms_d = 14'd7500;
            default: align_ms_d = 14'd10000;
        endcase
    end

    msc_decode u_lock_cap (
        .code_i(lock_code),
        .permille_o(lock_cap)
    );

    always_comb begin
        case (rate_code)
            3'h0: pulse_hz_d = 14'd50;
            3'h1: pulse_hz_d = 14'd100;
            3'h2: pulse_hz_d = 14'd250;
            3'h3: pulse_hz_d = 14'd500;
            3'h4: pulse_hz_d = 14'd1000;
            3'h5: pulse_hz_d = 14'd2000;
            3'h6: pulse_hz_d = 14'd5000;
            default: pulse_hz_d = 14'd10000;
        endcase
    end

    // tenths of percent; higher codes give zero and valid low
    always_comb begin
        thr_ok_d = 1'b1;
        case (thr_code)
            5'h00: thr_pct_d = 10'd25;
            5'h01: thr_pct_d = 10'd50;
            5'h02: thr_pct_d = 10'd75;
            5'h03: thr_pct_d = 10'd100;
            5'h04: thr_pct_d = 10'd125;
            5'h05: thr_pct_d = 10'd150;
            5'h06: thr_pct_d = 10'd200;
            5'h07: thr_pct_d = 10'd250;
            5'h08: thr_pct_d = 10'd300;
            5'h09: thr_pct_d = 10'd367;
            5'h0a: thr_pct_d = 10'd400;
            5'h0b: thr_pct_d = 10'd467;
            5'h0c: thr_pct_d = 10'd533;
            5'h0d: thr_pct_d = 10'd600;
            5'h0e: thr_pct_d = 10'd667;
            5'h0f: thr_pct_d = 10'd720;
            default: begin
                // stored as written, software keeps to 0..f
                thr_pct_d = 10'd0;
                thr_ok_d = 1'b0;
            end
        endcase
    end

    assign ang_d = 7'(ang_code) * 7'd30;
    assign rep_d = 3'(rep_code) + 3'd1;
    assign avg_d = (rep_code != 2'h0);

    // ****************************************
    // decoded output registers
    // ****************************************
    // no reset needed: cfg_q is zero in reset, so these settle to the
    // decode of zero two edges into reset and lag the register by one cycle
    always_ff @(posedge clk_i) begin
        rate_amps_q <= rate_amps_d;
        unl_q <= unl_d;
    end

    always_ff @(posedge clk_i) begin
        align_ms_q <= align_ms_d;
    end

    always_ff @(posedge clk_i) begin
        lock_cap_q <= lock_cap;
    end

    always_ff @(posedge clk_i) begin
        pulse_hz_q <= pulse_hz_d;
    end

    // value and valid flag move together, so no cycle shows a mixed pair
    always_ff @(posedge clk_i) begin
        thr_pct_q <= thr_pct_d;
        thr_ok_q <= thr_ok_d;
    end

    always_ff @(posedge clk_i) begin
        ang_q <= ang_d;
        rep_q <= rep_d;
        avg_q <= avg_d;
    end

    assign ramp_rate_amps_o = rate_amps_q;
    assign ramp_unlimited_o = unl_q;
    assign align_time_ms_o = align_ms_q;
    assign rotor_lock_current_cap_o = lock_cap_q;
    assign position_probe_pulse_rate_o = pulse_hz_q;
    assign position_probe_current_threshold_o = thr_pct_q;
    assign probe_threshold_valid_o = thr_ok_q;
    assign position_probe_advance_angle_o = ang_q;
    assign position_probe_repeat_count_o = rep_q;
    assign probe_average_o = avg_q;

    // ****************************************
    // open loop selections
    // ****************************************
    // reverse drive keeps its own open loop current select and A1, A2; the dedicated cap decode stays on the forward code
    assign ol_code = cfg_q[MSC_BACKWARD_BIT] ? reverse_open_loop_cap_i
        : open_loop_current_cap_i;
    assign open_loop_current_sel_o = ol_code;
    assign accel_a1_sel_o = cfg_q[MSC_BACKWARD_BIT] ? reverse_accel_a1_i
        : forward_accel_a1_i;
    assign accel_a2_sel_o = cfg_q[MSC_BACKWARD_BIT] ? reverse_accel_a2_i
        : forward_accel_a2_i;

    msc_decode u_ol_cap (
        .code_i(open_loop_current_cap_i),
        .permille_o(ol_cap)
    );
    always_ff @(posedge clk_i) begin
        ol_pick_q <= cfg_q[MSC_OL_SRC_BIT] ? general_current_cap_i : ol_cap;
    end
    assign open_loop_cap_o = ol_pick_q;

    assign torque_ref_rampdown_enable_o = cfg_q[MSC_RAMPDN_BIT];
    // braking gated by the reverse engine's request only while enabled
    assign active_brake_enable_o = cfg_q[MSC_BRAKE_BIT] && reverse_active_i;
endmodule

// ### msc_top_checker.sv
// Purpose: port-level checks for the startup configuration register
// Assumes: one-cycle registered ack, single clock, sync reset
// Notes: bound to msc_top below
`timescale 1ns/100ps
module msc_top_checker
    import msc_pkg::*;
(
    // clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // controls
    input wire logic reverse_active_i,
    input wire logic [1:0] startup_method_select_o,
    input wire logic method_align_o,
    input wire logic method_double_align_o,
    input wire logic method_position_detect_o,
    input wire logic method_slow_cycle_o,
    input wire logic [15:0] ramp_rate_amps_o,
    input wire logic ramp_unlimited_o,
    input wire logic [9:0] position_probe_current_threshold_o,
    input wire logic probe_threshold_valid_o,
    input wire logic [2:0] position_probe_repeat_count_o,
    input wire logic probe_average_o,
    input wire logic active_brake_enable_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence taken_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence method_wr_s;
        taken_s ##0 (we_i && adr_i == MSC_CFG1_OFFSET && sel_i[3]);
    endsequence
    ack_latency_a: assert property (taken_s |=> ack_o)
        else $error("ack missing after request");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    reserved_zero_a: assert property (ack_o |-> !dat_o[31] && !dat_o[8])
        else $error("reserved bit reads one");
    method_write_a: assert property (method_wr_s |=>
        startup_method_select_o == $past(dat_i[30:29])) else $error("method not stored");
    method_onehot_a: assert property ({method_slow_cycle_o, method_position_detect_o,
        method_double_align_o, method_align_o} == 4'h1 << startup_method_select_o)
        else $error("method flags wrong");
    ramp_unlimited_a: assert property (ramp_unlimited_o |-> ramp_rate_amps_o == 16'hffff)
        else $error("unlimited ramp value wrong");
    thr_invalid_a: assert property (!probe_threshold_valid_o |->
        position_probe_current_threshold_o == 10'h0) else $error("invalid threshold not zero");
    repeat_avg_a: assert property (probe_average_o ==
        (position_probe_repeat_count_o != 3'h1)) else $error("averaging flag wrong");
    brake_gate_a: assert property (active_brake_enable_o |-> reverse_active_i)
        else $error("brake without request");
endmodule
bind msc_top msc_top_checker msc_top_checker_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .reverse_active_i(reverse_active_i),
    .startup_method_select_o(startup_method_select_o), .method_align_o(method_align_o),
    .method_double_align_o(method_double_align_o),
    .method_position_detect_o(method_position_detect_o),
    .method_slow_cycle_o(method_slow_cycle_o), .ramp_rate_amps_o(ramp_rate_amps_o),
    .ramp_unlimited_o(ramp_unlimited_o),
    .position_probe_current_threshold_o(position_probe_current_threshold_o),
    .probe_threshold_valid_o(probe_threshold_valid_o),
    .position_probe_repeat_count_o(position_probe_repeat_count_o),
    .probe_average_o(probe_average_o), .active_brake_enable_o(active_brake_enable_o));

// ### msc_top_tb.sv
// Purpose: self-checking bench for the startup configuration register
// Assumes: classic Wishbone master, ack answered one cycle after the request
// Notes: every code of every field except threshold codes 10h up is swept through one table-driven loop
`timescale 1ns/100ps
module msc_top_tb
    import msc_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, rev = 1'b0;
    logic [7:0] adr_i = 8'h0;
    logic [3:0] sel_i = 4'h0, ol = 4'h0, kk;
    logic [9:0] gen = 10'h100, lc, thr, olc;
    logic [31:0] dat_i = 32'h0, dat_o, d;
    logic ack_o, m0, m1, m2, m3, unl, tv, avg, rd, br;
    logic [1:0] meth;
    logic [15:0] ramp;
    logic [13:0] at, pr;
    logic [6:0] ang;
    logic [2:0] rep;
    logic [3:0] ols, a1, a2;
    int checks = 0, n_fail = 0, cyc_n = 0;
    int ramp_t[16] = '{1, 5, 10, 25, 50, 100, 150, 250, 500, 1000, 2000, 5000, 10000,
        20000, 50000, 65535};
    int time_t[16] = '{10, 50, 100, 200, 300, 400, 500, 750, 1000, 1500, 2000, 3000,
        4000, 5000, 7500, 10000};
    int cap_t[16] = '{50, 100, 150, 200, 250, 300, 400, 500, 600, 650, 700, 750, 800,
        850, 900, 950};
    int thr_t[16] = '{25, 50, 75, 100, 125, 150, 200, 250, 300, 367, 400, 467, 533,
        600, 667, 720};
    int rate_t[8] = '{50, 100, 250, 500, 1000, 2000, 5000, 10000};
    msc_top msc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .general_current_cap_i(gen), .open_loop_current_cap_i(ol),
        .reverse_open_loop_cap_i(4'ha), .forward_accel_a1_i(4'h1),
        .forward_accel_a2_i(4'h2), .reverse_accel_a1_i(4'h3), .reverse_accel_a2_i(4'h4),
        .reverse_active_i(rev), .startup_method_select_o(meth), .method_align_o(m0),
        .method_double_align_o(m1), .method_position_detect_o(m2),
        .method_slow_cycle_o(m3), .ramp_rate_amps_o(ramp), .ramp_unlimited_o(unl),
        .align_time_ms_o(at), .rotor_lock_current_cap_o(lc),
        .position_probe_pulse_rate_o(pr), .position_probe_current_threshold_o(thr),
        .probe_threshold_valid_o(tv), .position_probe_advance_angle_o(ang),
        .position_probe_repeat_count_o(rep), .probe_average_o(avg), .open_loop_cap_o(olc),
        .torque_ref_rampdown_enable_o(rd), .active_brake_enable_o(br),
        .open_loop_current_sel_o(ols), .accel_a1_sel_o(a1), .accel_a2_sel_o(a2));
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one request held until ack is sampled high, then released
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] wd,
        input logic [3:0] s, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= wd;
        sel_i <= s;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        chk("ack", 32'h1, {31'h0, ack_o});
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s);
        logic [31:0] q;
        wb(a, 1'b1, wd, s, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(a, 1'b0, 32'h0, 4'hf, q);
        chk("rdata", e, q);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ceiling well above the roughly 130 cycles the tests need
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(MSC_CFG1_OFFSET, MSC_CFG1_RESET);
        $display("reset test done");
        wr(MSC_CFG1_OFFSET, 32'hffffffff, 4'hf);
        rdc(MSC_CFG1_OFFSET, MSC_CFG1_WMASK);
        @(negedge clk_i);
        chk("thr_valid", 32'h0, {31'h0, tv});
        chk("thr", 32'h0, {22'h0, thr});
        wr(MSC_CFG1_OFFSET, 32'h0, 4'hf);
        wr(MSC_CFG1_OFFSET, 32'hffffffff, 4'h2);
        rdc(MSC_CFG1_OFFSET, 32'h0000fe00);
        wr(8'h88, 32'hffffffff, 4'hf);
        rdc(MSC_CFG1_OFFSET, 32'h0000fe00);
        rdc(8'h88, 32'h0);
        rdc(8'h80, 32'h0);
        $display("access test done");
        for (int k = 0; k < 16; k++) begin
            kk = k[3:0];
            d = {1'b0, kk[1:0], kk, kk, kk, kk[2:0], 1'b0, kk, 1'b0, kk[1:0], kk[1:0], kk};
            wr(MSC_CFG1_OFFSET, d, 4'hf);
            rev <= kk[2];
            ol <= kk;
            gen <= 10'h100 + {6'h0, kk};
            rdc(MSC_CFG1_OFFSET, d);
            @(negedge clk_i);
            chk("method", {30'h0, kk[1:0]}, {30'h0, meth});
            chk("flags", 32'h1 << kk[1:0], {28'h0, m3, m2, m1, m0});
            chk("ramp", ramp_t[k], {16'h0, ramp});
            chk("unlim", {31'h0, kk == 4'hf}, {31'h0, unl});
            chk("align", time_t[k], {18'h0, at});
            chk("lockcap", cap_t[k], {22'h0, lc});
            chk("rate", rate_t[k % 8], {18'h0, pr});
            chk("thr", thr_t[k], {22'h0, thr});
            chk("angle", (k % 4) * 30, {25'h0, ang});
            chk("repeat", (k % 4) + 1, {29'h0, rep});
            chk("avg", {31'h0, kk[1:0] != 2'h0}, {31'h0, avg});
            chk("olcap", kk[3] ? 32'h100 + k : cap_t[k], {22'h0, olc});
            chk("rampdn", {31'h0, kk[2]}, {31'h0, rd});
            chk("brake", {31'h0, kk[1] & kk[2]}, {31'h0, br});
            chk("olsel", kk[0] ? 32'ha : k, {28'h0, ols});
            chk("a1", kk[0] ? 32'h3 : 32'h1, {28'h0, a1});
            chk("a2", kk[0] ? 32'h4 : 32'h2, {28'h0, a2});
        end
        $display("decode test done");
        complete_run();
    end
endmodule
